// *** logic/tcvd_params.svh ***
// Constants of the tapped control-voltage delay line
`ifndef TCVD_PARAMS_SVH
`define TCVD_PARAMS_SVH

// Sample and memory geometry
`define TCVD_SAMPLE_W 14
`define TCVD_MEM_AW 11
`define TCVD_MAX_GAP 511
`define TCVD_FIFO_DEPTH 32

// Range selector codes, three positions
`define TCVD_RANGE_SHORT 2'h0
`define TCVD_RANGE_MID 2'h1
`define TCVD_RANGE_LONG 2'h2

// Timing: core clock and internal rate limits
`define TCVD_CLK_HZ 200000000
`define TCVD_RATE_MIN_MHZ 500
`define TCVD_RATE_MAX_HZ 925
`define TCVD_SLOW_HALF ((`TCVD_CLK_HZ / (2 * `TCVD_RATE_MIN_MHZ)) * 1000)
`define TCVD_FAST_HALF (`TCVD_CLK_HZ / (2 * `TCVD_RATE_MAX_HZ))
`define TCVD_OCT_MAX 4'hB

`endif

// *** logic/tcvd_pkg.sv ***
// Types shared by the tapped control-voltage delay line
package tcvd_pkg;

  typedef logic [13:0] tcvd_sample_t;

  // Four tap values, tap one in the low bits
  typedef struct packed {
    tcvd_sample_t t4;
    tcvd_sample_t t3;
    tcvd_sample_t t2;
    tcvd_sample_t t1;
  } tcvd_taps_s;

  // Shift engine states
  typedef enum logic [5:0] {
    ST_CLR  = 6'h01,
    ST_IDLE = 6'h02,
    ST_RD2  = 6'h04,
    ST_RD3  = 6'h08,
    ST_RD4  = 6'h10,
    ST_FIN  = 6'h20
  } tcvd_state_e;

endpackage

// *** logic/tcvd_top.sv ***
// Tapped control-voltage delay line: sample FIFO and shift engine

`include "tcvd_params.svh"

// ****************************************
// Sample FIFO
// ****************************************
module tcvd_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic full, empty, push, pop;

  // Full and empty from pointer wrap bits
  assign full = (wr_reg[AW] != rd_reg[AW]) &&
                (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_reg[AW-1:0]];
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  // Pointer next values
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      wr_next = wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = rd_reg + 1'b1;
    end
  end

  // Pointer registers and storage write
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ****************************************
// Delay line top
// ****************************************
module tcvd_top #(
  parameter int SLOW_HALF = `TCVD_SLOW_HALF,
  parameter int FAST_HALF = `TCVD_FAST_HALF,
  parameter int FIFO_DEPTH = `TCVD_FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [13:0] sample_i,
  input wire logic in_patched_i,
  input wire logic [13:0] noise_i,
  input wire logic ext_clk_i,
  input wire logic ext_patched_i,
  input wire logic [7:0] rate_ctrl_i,
  input wire logic [8:0] delay_ctrl_i,
  input wire logic [1:0] range_sel_i,
  output tcvd_pkg::tcvd_taps_s taps_o,
  output logic clk_out_o,
  output logic cap_ready_o
);
  localparam int AW = `TCVD_MEM_AW;
  localparam int MW = 1 << AW;

  // ****************************************
  // Internal rate generator
  // ****************************************
  logic [27:0] rcnt_reg, rcnt_next, base, lim, step;
  logic [3:0] oct;
  logic int_clk_reg, int_clk_next;

  always_comb begin
    oct = rate_ctrl_i[7:4];
    if (oct > `TCVD_OCT_MAX) begin
      oct = `TCVD_OCT_MAX;
    end
    base = 28'(SLOW_HALF) >> oct;
    step = 28'((base >> 5) * rate_ctrl_i[3:0]);
    lim = base - step;
    if (lim < 28'(FAST_HALF)) begin
      lim = 28'(FAST_HALF);
    end
    rcnt_next = rcnt_reg + 28'h0000001;
    int_clk_next = int_clk_reg;
    if (rcnt_reg >= lim - 28'h0000001) begin
      rcnt_next = '0;
      int_clk_next = !int_clk_reg;
    end
  end

  // ****************************************
  // Clock select and sample capture
  // ****************************************
  logic sel_clk, edge_seen, prev_reg, prev_next;
  logic ready_reg, ready_next;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  tcvd_pkg::tcvd_sample_t cap_data, fifo_data;

  assign sel_clk = ext_patched_i ? ext_clk_i : int_clk_reg;
  assign cap_data = in_patched_i ? sample_i : noise_i;

  // Rising edge of the selected clock
  always_comb begin
    prev_next = sel_clk;
    edge_seen = sel_clk && !prev_reg;
    ready_next = fifo_in_ready;
  end

  tcvd_fifo #(
    .W(`TCVD_SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(edge_seen),
    .in_ready_o(fifo_in_ready),
    .in_data_i(cap_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // ****************************************
  // Gap length
  // ****************************************
  // nine-bit gap, at most 511 clocks
  logic [8:0] gap_d;
  logic [AW-1:0] gap;

  always_comb begin
    unique case (range_sel_i)
      `TCVD_RANGE_SHORT: gap_d = {4'h0, delay_ctrl_i[8:4]};
      `TCVD_RANGE_MID: gap_d = {2'h0, delay_ctrl_i[8:2]};
      default: gap_d = delay_ctrl_i;
    endcase
    // zero added delay, taps one clock apart
    gap = (gap_d == 9'h000) ? 11'h001 : {2'h0, gap_d};
  end

  // ****************************************
  // Shift engine
  // ****************************************
  tcvd_pkg::tcvd_state_e st_reg, st_next;
  logic [AW-1:0] wp_reg, wp_next, ra_reg, ra_next;
  tcvd_pkg::tcvd_sample_t mem [MW];
  tcvd_pkg::tcvd_sample_t rdata_reg;
  tcvd_pkg::tcvd_sample_t s1_reg, s1_next, s2_reg, s2_next;
  tcvd_pkg::tcvd_sample_t s3_reg, s3_next;
  tcvd_pkg::tcvd_taps_s taps_reg, taps_next;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  tcvd_pkg::tcvd_sample_t mem_wd;

  // Next state of the engine
  always_comb begin
    st_next = st_reg;
    wp_next = wp_reg;
    ra_next = ra_reg;
    s1_next = s1_reg;
    s2_next = s2_reg;
    s3_next = s3_reg;
    taps_next = taps_reg;
    mem_we = 1'b0;
    mem_wa = wp_reg;
    mem_wd = '0;
    fifo_pop = 1'b0;
    unique case (st_reg)
      tcvd_pkg::ST_CLR: begin
        // Zero the memory once after reset
        mem_we = 1'b1;
        wp_next = wp_reg + 11'h001;
        if (wp_reg == 11'(MW - 1)) begin
          st_next = tcvd_pkg::ST_IDLE;
        end
      end
      tcvd_pkg::ST_IDLE: begin
        if (fifo_out_valid) begin
          fifo_pop = 1'b1;
          mem_we = 1'b1;
          mem_wd = fifo_data;
          s1_next = fifo_data;
          // tap two lies one gap back
          ra_next = wp_reg - gap;
          st_next = tcvd_pkg::ST_RD2;
        end
      end
      tcvd_pkg::ST_RD2: begin
        ra_next = wp_reg - (gap << 1);
        st_next = tcvd_pkg::ST_RD3;
      end
      tcvd_pkg::ST_RD3: begin
        s2_next = rdata_reg;
        // tap four lies three gaps back
        ra_next = 11'(wp_reg - (gap << 1) - gap);
        st_next = tcvd_pkg::ST_RD4;
      end
      tcvd_pkg::ST_RD4: begin
        s3_next = rdata_reg;
        st_next = tcvd_pkg::ST_FIN;
      end
      tcvd_pkg::ST_FIN: begin
        // all four taps update at once
        taps_next = '{t4: rdata_reg, t3: s3_reg,
                      t2: s2_reg, t1: s1_reg};
        wp_next = wp_reg + 11'h001;
        st_next = tcvd_pkg::ST_IDLE;
      end
    endcase
  end

  // Memory write and registered read
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    rdata_reg <= mem[ra_reg];
  end

  // State registers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rcnt_reg <= '0;
      int_clk_reg <= 1'b0;
      prev_reg <= 1'b1;
      ready_reg <= 1'b0;
      st_reg <= tcvd_pkg::ST_CLR;
      wp_reg <= '0;
      ra_reg <= '0;
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      taps_reg <= '0;
    end else begin
      rcnt_reg <= rcnt_next;
      int_clk_reg <= int_clk_next;
      prev_reg <= prev_next;
      ready_reg <= ready_next;
      st_reg <= st_next;
      wp_reg <= wp_next;
      ra_reg <= ra_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      taps_reg <= taps_next;
    end
  end

  assign taps_o = taps_reg;
  assign clk_out_o = int_clk_reg;
  assign cap_ready_o = ready_reg; // FIFO can take a sample
endmodule

// *** sim/tcvd_chk.sv ***
// Port checker for the tapped delay line
module tcvd_chk #(
  parameter int SLOW_HALF = 4096
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [13:0] sample_i,
  input wire logic in_patched_i,
  input wire logic [13:0] noise_i,
  input wire logic ext_clk_i,
  input wire logic ext_patched_i,
  input wire logic [8:0] delay_ctrl_i,
  input wire tcvd_pkg::tcvd_taps_s taps_o,
  input wire logic clk_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXC = SLOW_HALF + 2;
  logic [11:0] up;
  logic [15:0] cc;
  logic ok;
  assign ok = up == 12'hFFF;
  // Settle time after reset, cycles since clock output moved
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      up <= 12'h0;
      cc <= 16'h0;
    end else begin
      up <= ok ? up : up + 12'h1;
      cc <= clk_out_o != $past(clk_out_o) ? 16'h0 : cc + 16'h1;
    end
  end
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_lat_in;
    ok && ext_patched_i && in_patched_i && $rose(ext_clk_i)
      |-> ##6 taps_o.t1 == $past(sample_i, 6);
  endproperty
  a_lat_in: assert property (p_lat_in) else $error("tap1 input");
  property p_lat_nz;
    ok && ext_patched_i && !in_patched_i && $rose(ext_clk_i)
      |-> ##6 taps_o.t1 == $past(noise_i, 6);
  endproperty
  a_lat_nz: assert property (p_lat_nz) else $error("tap1 noise");
  property p_zero;
    ok && ext_patched_i && in_patched_i && $rose(ext_clk_i)
      && sample_i == 14'h0 |-> ##6 taps_o.t1 == 14'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero sample");
  property p_shift;
    ok && delay_ctrl_i == 9'h0 && $changed(taps_o)
      |-> taps_o.t2 == $past(taps_o.t1) && taps_o.t3 == $past(taps_o.t2)
      && taps_o.t4 == $past(taps_o.t3);
  endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_hold;
    $changed(taps_o) |=> $stable(taps_o) [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("tap hold");
  property p_clk_min;
    $changed(clk_out_o) |=> $stable(clk_out_o) [*8];
  endproperty
  a_clk_min: assert property (p_clk_min) else $error("clk fast");
  property p_clk_max;
    cc <= MAXC;
  endproperty
  a_clk_max: assert property (p_clk_max) else $error("clk slow");
  property p_int;
    ok && !ext_patched_i && $rose(clk_out_o) |-> ##[5:7] $changed(taps_o);
  endproperty
  a_int: assert property (p_int) else $error("internal edge");
endmodule

bind tcvd_top tcvd_chk #(.SLOW_HALF(SLOW_HALF)) tcvd_chk_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sample_i(sample_i),
  .in_patched_i(in_patched_i), .noise_i(noise_i), .ext_clk_i(ext_clk_i),
  .ext_patched_i(ext_patched_i), .delay_ctrl_i(delay_ctrl_i),
  .taps_o(taps_o), .clk_out_o(clk_out_o)
);

// *** sim/tcvd_far.sv ***
// Far side: external clock source and noise converter
module tcvd_far (
  input wire logic core_clk_i,
  input wire logic en_i,
  output logic ext_clk_o,
  output logic [13:0] noise_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  initial begin
    ext_clk_o = 1'b0;
    noise_o = 14'h2A5B;
    cnt = 4'h0;
  end
  // Slow clock, held low when idle
  always @(negedge core_clk_i) begin
    noise_o <= {noise_o[12:0], noise_o[13] ^ noise_o[8]};
    cnt <= en_i && cnt != 4'h6 ? cnt + 4'h1 : 4'h0;
    ext_clk_o <= en_i && (cnt == 4'h6 ? !ext_clk_o : ext_clk_o);
  end
endmodule

// *** sim/testbench.sv ***
// Random and corner-case bench for the tapped delay line
`define CHK(n, e, a) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, a); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic in_patched_i = 1'b1;
  logic ext_patched_i = 1'b1;
  logic en = 1'b0;
  logic chk_en = 1'b1;
  logic ext_clk_i, clk_out_o, cap_ready_o, prev, full;
  logic [13:0] sample_i = 14'h0;
  logic [13:0] noise;
  logic [7:0] rate_ctrl_i = 8'hB0;
  logic [8:0] delay_ctrl_i = 9'h0;
  logic [1:0] range_sel_i = 2'h2;
  logic [31:0] seed = 32'hB686A1C6;
  logic [13:0] hist[$];
  int since = 99;
  int miscompares = 0;
  int total_checks = 0;
  int g;
  tcvd_pkg::tcvd_taps_s taps_o, held;
  tcvd_top #(.SLOW_HALF(4096), .FAST_HALF(16)) tcvd_top_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sample_i(sample_i),
    .in_patched_i(in_patched_i), .noise_i(noise), .ext_clk_i(ext_clk_i),
    .ext_patched_i(ext_patched_i), .rate_ctrl_i(rate_ctrl_i),
    .delay_ctrl_i(delay_ctrl_i), .range_sel_i(range_sel_i),
    .taps_o(taps_o), .clk_out_o(clk_out_o), .cap_ready_o(cap_ready_o)
  );
  tcvd_far tcvd_far_inst (
    .core_clk_i(core_clk_i), .en_i(en), .ext_clk_o(ext_clk_i), .noise_o(noise)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Gap in edges from delay value and range
  function automatic int gap();
    int d;
    d = int'(range_sel_i == 2'h0 ? delay_ctrl_i >> 4 :
      range_sel_i == 2'h1 ? delay_ctrl_i >> 2 : delay_ctrl_i);
    return d == 0 ? 1 : d;
  endfunction
  // Sample taken k edges before the newest, zero before the start
  function automatic logic [13:0] back(input int k);
    return k < hist.size() ? hist[hist.size() - 1 - k] : 14'h0;
  endfunction
  initial forever #2.5 core_clk_i = !core_clk_i;
  // Record taken samples, compare taps once settled
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      hist.delete();
      prev <= 1'b1;
    end else begin
      prev <= ext_clk_i;
      since <= since < 99 ? since + 1 : since;
      if (ext_patched_i && ext_clk_i && !prev) begin
        hist.push_back(in_patched_i ? sample_i : noise);
        since <= 0;
      end
      if (since == 6 && chk_en) begin
        g = gap();
        `CHK("tap1", back(0), taps_o.t1)
        `CHK("tap2", back(g), taps_o.t2)
        `CHK("tap3", back(2 * g), taps_o.t3)
        `CHK("tap4", back(3 * g), taps_o.t4)
      end
    end
  end
  // Clock n edges with random samples, zeros often
  task automatic run(input int n);
    en = 1'b1;
    repeat (n * 14) begin
      @(negedge core_clk_i);
      seed = xs(seed);
      sample_i = seed[1:0] == 2'h0 ? 14'h0 : seed[15:2];
      rate_ctrl_i = seed[31:24];
    end
    en = 1'b0;
    repeat (20) @(negedge core_clk_i);
  endtask
  task automatic reset();
    rstn_i = 1'b0;
    repeat (16) @(negedge core_clk_i);
    rstn_i = 1'b1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    reset();
    repeat (4200) @(negedge core_clk_i);
    run(12);
    in_patched_i = 1'b0;
    run(8);
    in_patched_i = 1'b1;
    $display("test basic and noise done");
    for (int r = 0; r < 4; r++) begin
      range_sel_i = 2'(r);
      delay_ctrl_i = seed[8:0] | 9'h1;
      run(30);
    end
    $display("test ranges done");
    held = taps_o;
    repeat (200) @(negedge core_clk_i);
    `CHK("frozen", held, taps_o)
    range_sel_i = 2'h2;
    delay_ctrl_i = 9'h1FF;
    run(1560);
    $display("test long delay done");
    chk_en = 1'b0;
    delay_ctrl_i = 9'h0;
    reset();
    full = 1'b0;
    en = 1'b1;
    repeat (700) begin
      @(negedge core_clk_i);
      full = full | !cap_ready_o;
    end
    en = 1'b0;
    `CHK("fifo full", 1'b1, full)
    repeat (4200) @(negedge core_clk_i);
    `CHK("fifo drained", 1'b1, cap_ready_o)
    $display("test buffer done");
    ext_patched_i = 1'b0;
    in_patched_i = 1'b0;
    held = taps_o;
    run(400);
    `CHK("internal", 1'b1, taps_o !== held)
    $display("test internal clock done");
    summarize();
  end
endmodule
